// ==== ccp_sync_shutdown_gating_ctrl.sv ====
// Shutdown, gating, steering and sync control of one capture/compare unit
// Summary of operation
// RULE1 - Sync code all ones: time base free runs, rolls at period or FFFFh.
// RULE2 - Five-bit code picks the time base sync source; reserved codes idle.
// RULE3 - Auto restart clears shutdown flag at next period once source gone.
// RULE4 - Without auto restart, shutdown holds until software clears flag.
// RULE5 - Gate mode set defers shutdown to next reset or rollover.
// RULE6 - Software force acts like an asserted source, honoring gate mode.
// RULE7 - Eight-bit mask picks which sources cause shutdown or gating.
// RULE8 - Enable sync set: pin enables update only at reset or rollover.
// RULE9 - Pin enable set gives the pin to the unit, clear releases it.
// RULE10 - Gate mode 10: falling gate edge disables further captures.
// RULE11 - Gate mode 01: rising gate edge enables further captures.
// RULE12 - Gate mode 00: capture follows gate level; mode 11 reserved.
// RULE13 - Aux select: 11 events, 10 mode signal, 01 rollover, 00 off.
// RULE14 - Capture source: 000 pin, 001-011 comparators, 100-111 logic cells.
// RULE15 - While shutdown flag set, outputs hold their shutdown state.
// RULE16 - Shutdown state per group: 11 active, 10 inactive, 0x released.
// RULE17 - Arm bit write one arms one-shot gating; arm bit reads zero.
// RULE18 - Reserved sync or gate codes behave as no source selected.
`timescale 1ns/100ps
module ccp_sync_shutdown_gating_ctrl (
   input wire logic aclk,
   input wire logic aresetn,
   input wire logic ce,
   input wire logic [11:0] awaddr,
   input wire logic awvalid,
   output logic awready,
   input wire logic [31:0] wdata,
   input wire logic [3:0] wstrb,
   input wire logic wvalid,
   output logic wready,
   output logic [1:0] bresp,
   output logic bvalid,
   input wire logic bready,
   input wire logic [11:0] araddr,
   input wire logic arvalid,
   output logic arready,
   output logic [31:0] rdata,
   output logic [1:0] rresp,
   output logic rvalid,
   input wire logic rready,
   input wire logic ad_start,
   input wire logic [2:0] cmp_trig,
   input wire logic [3:0] clc_out,
   input wire logic [4:0] ext_int,
   input wire logic [6:0] unit_sync,
   input wire logic [2:0] cmp_out,
   input wire logic fault_input_a,
   input wire logic fault_input_b,
   input wire logic capture_input_pin,
   input wire logic [5:0] pwm_in,
   input wire logic compare_event,
   input wire logic timer_mode,
   input wire logic aux_mode_sig,
   output logic [5:0] pin_out,
   output logic [5:0] pin_oe,
   output logic capture_event,
   output logic aux_out,
   output logic tb_event,
   output logic irq
);
   function automatic logic [1:0] sync_sel(input logic [4:0] c, input logic [25:0] v);
      logic [1:0] r;
      r = 2'b00;
      if (c == sdg_pkg::SYNC_AD) begin
         r = {1'b1, v[0]};
      end else if (c >= sdg_pkg::SYNC_CMP_LO && c <= sdg_pkg::SYNC_CMP_HI) begin
         r = {1'b1, v[c - sdg_pkg::SYNC_CMP_OFS]};
      end else if (c >= sdg_pkg::SYNC_CLC_LO && c <= sdg_pkg::SYNC_CLC_HI) begin
         r = {1'b1, v[c - sdg_pkg::SYNC_CLC_OFS]};
      end else if (c >= sdg_pkg::SYNC_INT_LO && c <= sdg_pkg::SYNC_INT_HI) begin
         r = {1'b1, v[c - sdg_pkg::SYNC_INT_OFS]};
      end else if (c <= sdg_pkg::SYNC_UNIT_HI) begin
         r = {1'b1, v[c + sdg_pkg::SYNC_UNIT_OFS]};
      end
      return r;
   endfunction : sync_sel

   function automatic logic addr_hit(input logic [11:0] a, input logic [9:0] idx);
      return (a[11:2] == idx) && (a[1:0] == 2'h0);
   endfunction : addr_hit

   function automatic logic [15:0] merge(input logic [15:0] old, input logic [31:0] d,
                                         input logic [3:0] s, input logic [15:0] m);
      logic [15:0] r;
      r = old;
      if (s[0]) begin
         r[7:0] = d[7:0];
      end
      if (s[1]) begin
         r[15:8] = d[15:8];
      end
      return r & m;
   endfunction : merge

   logic [25:0] meta_reg, pin_s_reg, pin_p_reg;
   logic [15:0] ctl_lo_reg, ctl_lo_next, ctl_hi_reg, ctl_hi_next;
   logic [15:0] period_reg, period_next, sync_cfg_reg, sync_cfg_next;
   logic [15:0] count_reg, count_next;
   logic [3:0] irq_st_reg, irq_st_next, irq_msk_reg, irq_msk_next;
   logic active_reg, active_next, capdis_reg, capdis_next, armed_reg, armed_next;
   logic gate_prev_reg, cap_prev_reg;
   logic [5:0] oe_live_reg, oe_live_next;
   logic aw_full_reg, w_full_reg;
   logic [11:0] awaddr_q_reg;
   logic [31:0] wdata_q_reg;
   logic [3:0] wstrb_q_reg;

   // Pin synchronisers
   wire [25:0] pins_raw = {capture_input_pin, fault_input_b, fault_input_a, cmp_out,
                           unit_sync, ext_int, clc_out, cmp_trig, ad_start};
   wire [3:0] clc_s = pin_s_reg[7:4];
   wire [6:0] unit_s = pin_s_reg[19:13];
   wire [2:0] cmpo_s = pin_s_reg[22:20];

   // Bus handshakes and decode
   wire aw_hs = awvalid && awready;
   wire w_hs = wvalid && wready;
   wire ar_hs = arvalid && arready;
   wire do_write = aw_full_reg && w_full_reg && !bvalid;
   wire hw_lo = do_write && addr_hit(awaddr_q_reg, sdg_pkg::IDX_CTL_LO);
   wire hw_hi = do_write && addr_hit(awaddr_q_reg, sdg_pkg::IDX_CTL_HI);
   wire hw_per = do_write && addr_hit(awaddr_q_reg, sdg_pkg::IDX_PERIOD);
   wire hw_syn = do_write && addr_hit(awaddr_q_reg, sdg_pkg::IDX_SYNC);
   wire hw_st = do_write && addr_hit(awaddr_q_reg, sdg_pkg::IDX_STAT);
   wire hw_ist = do_write && addr_hit(awaddr_q_reg, sdg_pkg::IDX_IRQ_ST);
   wire hw_msk = do_write && addr_hit(awaddr_q_reg, sdg_pkg::IDX_IRQ_MSK);
   wire w_mapped = hw_lo | hw_hi | hw_per | hw_syn | hw_st | hw_ist | hw_msk;
   wire st_lane = hw_st && wstrb_q_reg[0];
   wire sw_clr_active = st_lane && wdata_q_reg[sdg_pkg::ST_ACTIVE];
   wire sw_clr_capdis = st_lane && wdata_q_reg[sdg_pkg::ST_CAPDIS];
   wire arm_set = st_lane && wdata_q_reg[sdg_pkg::ST_ARM]; // RULE17

   // Control fields
   wire auto_restart_en = ctl_lo_reg[sdg_pkg::CL_RESTART];
   wire shutdown_gate_mode = ctl_lo_reg[sdg_pkg::CL_GMODE];
   wire soft_shutdown_force = ctl_lo_reg[sdg_pkg::CL_SOFT];
   wire [7:0] shutdown_source_mask = ctl_lo_reg[7:0];
   wire out_enable_sync = ctl_hi_reg[sdg_pkg::CH_OESYNC];
   wire [5:0] out_pin_enables = ctl_hi_reg[sdg_pkg::CH_OE_LSB +: 6];
   wire [1:0] capture_gate_mode = ctl_hi_reg[sdg_pkg::CH_GATE_LSB +: 2];
   wire [1:0] aux_out_select = ctl_hi_reg[sdg_pkg::CH_AUX_LSB +: 2];
   wire [2:0] capture_source_select = ctl_hi_reg[2:0];
   wire [4:0] sync_code = sync_cfg_reg[4:0];
   wire [1:0] shutdown_state_group_a = sync_cfg_reg[sdg_pkg::SY_GRPA_LSB +: 2];
   wire [1:0] shutdown_state_group_b = sync_cfg_reg[sdg_pkg::SY_GRPB_LSB +: 2];

   // Time base sync and rollover
   wire [1:0] sync_now = sync_sel(sync_code, pin_s_reg); // RULE2 RULE18
   wire [1:0] sync_old = sync_sel(sync_code, pin_p_reg);
   wire sync_hit = sync_now[1] && sync_now[0] && !sync_old[0]; // RULE2
   wire rollover = (count_reg == period_reg) || (count_reg == sdg_pkg::TB_MAX); // RULE1
   wire tb_evt = rollover || sync_hit;
   assign count_next = tb_evt ? 16'h0000 : count_reg + 16'h0001;

   // Shutdown sources and flag
   wire [7:0] sd_src = {pin_s_reg[24], pin_s_reg[23], clc_s[3], unit_s[2],
                        unit_s[6], cmpo_s};
   wire src_hit = |(sd_src & shutdown_source_mask); // RULE7
   wire sd_req = src_hit || soft_shutdown_force; // RULE6
   wire sd_enter = sd_req && (!shutdown_gate_mode || tb_evt); // RULE5
   wire sd_pend = sd_req && shutdown_gate_mode && !active_reg;
   wire auto_clr = auto_restart_en && tb_evt && !sd_req; // RULE3
   wire sd_clr = sw_clr_active || auto_clr; // RULE4
   assign active_next = sd_enter || (active_reg && !sd_clr);

   // Capture gating
   wire gate_rise = sd_req && !gate_prev_reg;
   wire gate_fall = !sd_req && gate_prev_reg;
   wire fire_rise = armed_reg && capture_gate_mode == sdg_pkg::GATE_RISE && gate_rise;
   wire fire_fall = armed_reg && capture_gate_mode == sdg_pkg::GATE_FALL && gate_fall;
   wire fire = fire_rise || fire_fall;
   assign armed_next = arm_set || (armed_reg && !fire); // RULE17
   wire capdis_hold = capdis_reg && !sw_clr_capdis;
   always_comb begin
      unique case (capture_gate_mode)
         sdg_pkg::GATE_LEVEL: capdis_next = !sd_req; // RULE12
         sdg_pkg::GATE_RISE: capdis_next = fire_rise ? 1'b0 : capdis_hold; // RULE11
         sdg_pkg::GATE_FALL: capdis_next = fire_fall ? 1'b1 : capdis_hold; // RULE10
         default: capdis_next = 1'b0; // RULE18
      endcase
   end

   // Capture source and event
   wire [7:0] cap_vec = {clc_s, cmpo_s, pin_s_reg[25]};
   wire cap_lvl = cap_vec[capture_source_select]; // RULE14
   wire cap_next = cap_lvl && !cap_prev_reg && !capdis_reg;

   // Output steering and shutdown states
   assign oe_live_next = (!out_enable_sync || tb_evt) ? out_pin_enables : oe_live_reg; // RULE8
   wire [5:0] pin_out_next, pin_oe_next;
   genvar gi;
   generate
      for (gi = 0; gi < 6; gi++) begin : g_pin
         wire [1:0] st = (gi % 2 == 0) ? shutdown_state_group_a : shutdown_state_group_b;
         assign pin_out_next[gi] = active_reg ? (st == sdg_pkg::SD_ACTIVE) : pwm_in[gi]; // RULE15 RULE16
         assign pin_oe_next[gi] = oe_live_reg[gi] && (!active_reg || st[1]); // RULE9 RULE16
      end
   endgenerate

   // Auxiliary output
   logic aux_next;
   always_comb begin
      unique case (aux_out_select)
         sdg_pkg::AUX_EVT: aux_next = (cap_next || compare_event) && !timer_mode; // RULE13
         sdg_pkg::AUX_MODE: aux_next = aux_mode_sig; // RULE13
         sdg_pkg::AUX_ROLL: aux_next = rollover; // RULE13
         sdg_pkg::AUX_OFF: aux_next = 1'b0; // RULE13
      endcase
   end

   // Register writes
   assign ctl_lo_next = hw_lo ? merge(ctl_lo_reg, wdata_q_reg, wstrb_q_reg,
                                      sdg_pkg::CTL_LO_MASK) : ctl_lo_reg;
   assign ctl_hi_next = hw_hi ? merge(ctl_hi_reg, wdata_q_reg, wstrb_q_reg,
                                      sdg_pkg::CTL_HI_MASK) : ctl_hi_reg;
   assign period_next = hw_per ? merge(period_reg, wdata_q_reg, wstrb_q_reg,
                                       16'hFFFF) : period_reg;
   assign sync_cfg_next = hw_syn ? merge(sync_cfg_reg, wdata_q_reg, wstrb_q_reg,
                                         sdg_pkg::SYNC_MASK) : sync_cfg_reg;
   assign irq_msk_next = (hw_msk && wstrb_q_reg[0]) ? wdata_q_reg[3:0] : irq_msk_reg;

   // Interrupt status, cleared by read, set wins
   wire rd_ist = ar_hs && addr_hit(araddr, sdg_pkg::IDX_IRQ_ST);
   wire [3:0] irq_evt = {rollover, capdis_next && !capdis_reg,
                         active_reg && !active_next, active_next && !active_reg};
   assign irq_st_next = (irq_st_reg & ~{4{rd_ist}}) | irq_evt;

   // Read mux
   wire [15:0] stat_word = {12'h000, sd_pend, 1'b0, capdis_reg, active_reg}; // RULE17
   logic [15:0] rd_word;
   logic rd_ok;
   always_comb begin
      rd_ok = 1'b1;
      rd_word = 16'h0000;
      if (addr_hit(araddr, sdg_pkg::IDX_CTL_LO)) begin
         rd_word = ctl_lo_reg;
      end else if (addr_hit(araddr, sdg_pkg::IDX_CTL_HI)) begin
         rd_word = ctl_hi_reg;
      end else if (addr_hit(araddr, sdg_pkg::IDX_PERIOD)) begin
         rd_word = period_reg;
      end else if (addr_hit(araddr, sdg_pkg::IDX_SYNC)) begin
         rd_word = sync_cfg_reg;
      end else if (addr_hit(araddr, sdg_pkg::IDX_STAT)) begin
         rd_word = stat_word;
      end else if (addr_hit(araddr, sdg_pkg::IDX_IRQ_ST)) begin
         rd_word = {12'h000, irq_st_reg};
      end else if (addr_hit(araddr, sdg_pkg::IDX_IRQ_MSK)) begin
         rd_word = {12'h000, irq_msk_reg};
      end else begin
         rd_ok = 1'b0;
      end
   end

   wire aw_full_next = aw_hs || (aw_full_reg && !do_write);
   wire w_full_next = w_hs || (w_full_reg && !do_write);
   wire rvalid_next = ar_hs || (rvalid && !rready);

   // Bus slave state
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         {aw_full_reg, w_full_reg, awready, wready, bvalid, arready, rvalid} <= 7'h00;
         bresp <= sdg_pkg::RESP_OKAY;
         rresp <= sdg_pkg::RESP_OKAY;
         rdata <= 32'h00000000;
         awaddr_q_reg <= 12'h000;
         wdata_q_reg <= 32'h00000000;
         wstrb_q_reg <= 4'h0;
      end else if (ce) begin
         aw_full_reg <= aw_full_next;
         w_full_reg <= w_full_next;
         awready <= !aw_full_next;
         wready <= !w_full_next;
         arready <= !rvalid_next;
         rvalid <= rvalid_next;
         if (aw_hs) begin
            awaddr_q_reg <= awaddr;
         end
         if (w_hs) begin
            wdata_q_reg <= wdata;
            wstrb_q_reg <= wstrb;
         end
         if (do_write) begin
            bvalid <= 1'b1;
            bresp <= w_mapped ? sdg_pkg::RESP_OKAY : sdg_pkg::RESP_SLVERR;
         end else if (bready) begin
            bvalid <= 1'b0;
         end
         if (ar_hs) begin
            rdata <= {16'h0000, rd_word};
            rresp <= rd_ok ? sdg_pkg::RESP_OKAY : sdg_pkg::RESP_SLVERR;
         end
      end
   end

   // Configuration registers
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         ctl_lo_reg <= sdg_pkg::CTL_LO_RST;
         ctl_hi_reg <= sdg_pkg::CTL_HI_RST;
         period_reg <= sdg_pkg::PERIOD_RST;
         sync_cfg_reg <= sdg_pkg::SYNC_RST;
         irq_msk_reg <= sdg_pkg::IRQ_RST;
      end else if (ce) begin
         ctl_lo_reg <= ctl_lo_next;
         ctl_hi_reg <= ctl_hi_next;
         period_reg <= period_next;
         sync_cfg_reg <= sync_cfg_next;
         irq_msk_reg <= irq_msk_next;
      end
   end

   // Block state and outputs
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         {meta_reg, pin_s_reg, pin_p_reg} <= 78'h0;
         count_reg <= 16'h0000;
         {active_reg, capdis_reg, armed_reg, gate_prev_reg, cap_prev_reg} <= 5'h00;
         oe_live_reg <= 6'h00;
         irq_st_reg <= sdg_pkg::IRQ_RST;
         {pin_out, pin_oe} <= 12'h000;
         {capture_event, aux_out, tb_event, irq} <= 4'h0;
      end else if (ce) begin
         meta_reg <= pins_raw;
         pin_s_reg <= meta_reg;
         pin_p_reg <= pin_s_reg;
         count_reg <= count_next; // RULE1
         active_reg <= active_next; // RULE3 RULE4 RULE5
         capdis_reg <= capdis_next;
         armed_reg <= armed_next;
         gate_prev_reg <= sd_req;
         cap_prev_reg <= cap_lvl;
         oe_live_reg <= oe_live_next;
         irq_st_reg <= irq_st_next;
         pin_out <= pin_out_next;
         pin_oe <= pin_oe_next;
         capture_event <= cap_next;
         aux_out <= aux_next;
         tb_event <= tb_evt;
         irq <= |(irq_st_next & irq_msk_next);
      end
   end

   default clocking cb @(posedge aclk);
   endclocking
   default disable iff (!aresetn);

   property p_free_run;
      ce && sync_code == sdg_pkg::SYNC_NONE && count_reg == period_reg |=> count_reg == 16'h0000;
   endproperty
   a_free_run: assert property (p_free_run) else $error("free run missed rollover"); // RULE1
   property p_sync_reset;
      ce && sync_hit |=> count_reg == 16'h0000 && tb_event;
   endproperty
   a_sync_reset: assert property (p_sync_reset) else $error("sync did not reset"); // RULE2
   property p_auto;
      ce && active_reg && auto_restart_en && tb_evt && !sd_req |=> !active_reg;
   endproperty
   a_auto: assert property (p_auto) else $error("auto restart failed"); // RULE3
   property p_hold;
      ce && active_reg && !auto_restart_en && !sw_clr_active |=> active_reg;
   endproperty
   a_hold: assert property (p_hold) else $error("shutdown dropped"); // RULE4
   property p_defer;
      ce && !active_reg && shutdown_gate_mode && !tb_evt |=> !active_reg;
   endproperty
   a_defer: assert property (p_defer) else $error("shutdown not deferred"); // RULE5
   property p_soft;
      ce && soft_shutdown_force && !shutdown_gate_mode |=> active_reg;
   endproperty
   a_soft: assert property (p_soft) else $error("soft force ignored"); // RULE6
   property p_mask;
      shutdown_source_mask == 8'h00 && !soft_shutdown_force |-> !sd_req;
   endproperty
   a_mask: assert property (p_mask) else $error("unmasked source leak"); // RULE7
   property p_oe_sync;
      ce && out_enable_sync && !tb_evt |=> $stable(oe_live_reg);
   endproperty
   a_oe_sync: assert property (p_oe_sync) else $error("enable changed early"); // RULE8
   property p_release;
      ce && !oe_live_reg[0] |=> !pin_oe[0];
   endproperty
   a_release: assert property (p_release) else $error("pin not released"); // RULE9
   property p_gate_fall;
      ce && fire_fall |=> capdis_reg ##1 !armed_reg || $past(arm_set);
   endproperty
   a_gate_fall: assert property (p_gate_fall) else $error("fall gate failed"); // RULE10
   property p_gate_rise;
      ce && fire_rise |=> !capdis_reg;
   endproperty
   a_gate_rise: assert property (p_gate_rise) else $error("rise gate failed"); // RULE11
   property p_level;
      ce && capture_gate_mode == sdg_pkg::GATE_LEVEL |=> capdis_reg == !$past(sd_req);
   endproperty
   a_level: assert property (p_level) else $error("level gate wrong"); // RULE12
   property p_sd_state;
      ce && active_reg && oe_live_reg[0] && shutdown_state_group_a == 2'h2
         |=> pin_oe[0] && !pin_out[0];
   endproperty
   a_sd_state: assert property (p_sd_state) else $error("shutdown state wrong"); // RULE15

   c_shutdown: cover property (ce && sd_enter ##[1:20] ce && auto_clr);
   c_fall_gate: cover property (ce && fire_fall);
   c_sync: cover property (ce && sync_hit);
   c_capture: cover property (capture_event);
endmodule : ccp_sync_shutdown_gating_ctrl

// ==== sdg_far_model.sv ====
// Far side sources: comparators, logic cells, pins and faults
`timescale 1ns/100ps
module sdg_far_model #(
   parameter int DLY = 1
) (
   input wire logic aclk,
   input wire logic [25:0] want,
   output logic ad_start,
   output logic [2:0] cmp_trig,
   output logic [3:0] clc_out,
   output logic [4:0] ext_int,
   output logic [6:0] unit_sync,
   output logic [2:0] cmp_out,
   output logic capture_input_pin,
   output logic fault_input_a,
   output logic fault_input_b
);
   logic [25:0] q [0:3] = '{default: '0};
   // Levels reach the pins DLY cycles after they are asked for
   always @(posedge aclk) begin
      q[0] <= want;
      for (int i = 1; i < 4; i++) q[i] <= q[i-1];
   end
   assign {fault_input_b, fault_input_a, capture_input_pin, cmp_out, unit_sync, ext_int, clc_out,
      cmp_trig, ad_start} = q[DLY-1];
endmodule : sdg_far_model

// ==== sdg_pkg.sv ====
// Constants for the shutdown, gating and steering control block
package sdg_pkg;
   localparam logic [9:0] IDX_CTL_LO = 10'h304;
   localparam logic [9:0] IDX_CTL_HI = 10'h306;
   localparam logic [9:0] IDX_PERIOD = 10'h310;
   localparam logic [9:0] IDX_SYNC = 10'h312;
   localparam logic [9:0] IDX_STAT = 10'h314;
   localparam logic [9:0] IDX_IRQ_ST = 10'h316;
   localparam logic [9:0] IDX_IRQ_MSK = 10'h318;
   localparam logic [15:0] CTL_LO_RST = 16'h0000;
   localparam logic [15:0] CTL_HI_RST = 16'h0000;
   localparam logic [15:0] PERIOD_RST = 16'hFFFF;
   localparam logic [15:0] SYNC_RST = 16'h0000;
   localparam logic [3:0] IRQ_RST = 4'h0;
   localparam logic [15:0] CTL_LO_MASK = 16'hD0FF;
   localparam logic [15:0] CTL_HI_MASK = 16'hBFDF;
   localparam logic [15:0] SYNC_MASK = 16'h0F1F;
   localparam int CL_RESTART = 15;
   localparam int CL_GMODE = 14;
   localparam int CL_SOFT = 12;
   localparam int CH_OESYNC = 15;
   localparam int CH_OE_LSB = 8;
   localparam int CH_GATE_LSB = 6;
   localparam int CH_AUX_LSB = 3;
   localparam int SY_GRPA_LSB = 8;
   localparam int SY_GRPB_LSB = 10;
   localparam int ST_ACTIVE = 0;
   localparam int ST_CAPDIS = 1;
   localparam int ST_ARM = 2;
   localparam logic [4:0] SYNC_NONE = 5'h1F;
   localparam logic [4:0] SYNC_AD = 5'h1B;
   localparam logic [4:0] SYNC_CMP_LO = 5'h18;
   localparam logic [4:0] SYNC_CMP_HI = 5'h1A;
   localparam logic [4:0] SYNC_CMP_OFS = 5'h17;
   localparam logic [4:0] SYNC_CLC_LO = 5'h10;
   localparam logic [4:0] SYNC_CLC_HI = 5'h13;
   localparam logic [4:0] SYNC_CLC_OFS = 5'h0C;
   localparam logic [4:0] SYNC_INT_LO = 5'h09;
   localparam logic [4:0] SYNC_INT_HI = 5'h0D;
   localparam logic [4:0] SYNC_INT_OFS = 5'h01;
   localparam logic [4:0] SYNC_UNIT_HI = 5'h06;
   localparam logic [4:0] SYNC_UNIT_OFS = 5'h0D;
   localparam logic [1:0] GATE_LEVEL = 2'h0;
   localparam logic [1:0] GATE_RISE = 2'h1;
   localparam logic [1:0] GATE_FALL = 2'h2;
   localparam logic [1:0] AUX_OFF = 2'h0;
   localparam logic [1:0] AUX_ROLL = 2'h1;
   localparam logic [1:0] AUX_MODE = 2'h2;
   localparam logic [1:0] AUX_EVT = 2'h3;
   localparam logic [1:0] SD_ACTIVE = 2'h3;
   localparam logic [15:0] TB_MAX = 16'hFFFF;
   localparam logic [1:0] RESP_OKAY = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;
endpackage : sdg_pkg

// ==== tb.sv ====
// Self-checking testbench of the shutdown, gating and steering block
`timescale 1ns/100ps
module tb;
   localparam logic [11:0] A_LO = {sdg_pkg::IDX_CTL_LO, 2'b00};
   localparam logic [11:0] A_HI = {sdg_pkg::IDX_CTL_HI, 2'b00};
   localparam logic [11:0] A_PER = {sdg_pkg::IDX_PERIOD, 2'b00};
   localparam logic [11:0] A_SYN = {sdg_pkg::IDX_SYNC, 2'b00};
   localparam logic [11:0] A_ST = {sdg_pkg::IDX_STAT, 2'b00};
   localparam logic [11:0] A_IST = {sdg_pkg::IDX_IRQ_ST, 2'b00};
   localparam logic [11:0] A_MSK = {sdg_pkg::IDX_IRQ_MSK, 2'b00};
   logic aclk = 1'b0;
   logic aresetn = 1'b0;
   logic [11:0] awaddr = '0;
   logic [11:0] araddr = '0;
   logic awvalid = 1'b0;
   logic wvalid = 1'b0;
   logic bready = 1'b1;
   logic arvalid = 1'b0;
   logic rready = 1'b1;
   logic aux_mode_sig = 1'b0;
   logic [31:0] wdata = '0;
   logic [3:0] wstrb = '0;
   logic [25:0] want = '0;
   logic [31:0] rdata, rd;
   logic [1:0] bresp, rresp, rs;
   logic awready, wready, bvalid, arready, rvalid, capture_event, aux_out, tb_event, irq, f;
   logic [5:0] pin_out, pin_oe;
   logic ad_start, fault_input_a, fault_input_b, capture_input_pin;
   logic [2:0] cmp_trig, cmp_out;
   logic [3:0] clc_out;
   logic [4:0] ext_int;
   logic [6:0] unit_sync;
   int mismatches = 0;
   int checked = 0;
   always #2.5 aclk = ~aclk;
   sdg_far_model #(.DLY(2)) u_far (.*);
   ccp_sync_shutdown_gating_ctrl u_dut (.ce(1'b1), .pwm_in(6'h2A), .compare_event(1'b0),
      .timer_mode(1'b0), .*);
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      checked++;
      if (got !== exp) begin
         mismatches++;
         $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask : chk
   task automatic wr(input logic [11:0] a, input logic [15:0] d);
      logic ta, tw, tb;
      awaddr <= a;
      wdata <= {16'h0000, d};
      wstrb <= 4'h3;
      awvalid <= 1'b1;
      wvalid <= 1'b1;
      do begin
         @(negedge aclk);
         ta = awvalid && awready;
         tw = wvalid && wready;
         tb = bvalid;
         rs = bresp;
         @(posedge aclk);
         if (ta) awvalid <= 1'b0;
         if (tw) wvalid <= 1'b0;
      end while (!tb);
   endtask : wr
   task automatic rdr(input logic [11:0] a);
      logic ta, tr;
      araddr <= a;
      arvalid <= 1'b1;
      do begin
         @(negedge aclk);
         ta = arvalid && arready;
         tr = rvalid;
         rd = rdata;
         rs = rresp;
         @(posedge aclk);
         if (ta) arvalid <= 1'b0;
      end while (!tr);
   endtask : rdr
   // Waits up to n cycles for tb_event (0), capture_event (1) or aux_out (2)
   task automatic hit(input int sel, input int n);
      f = 1'b0;
      while (n > 0 && !f) begin
         @(negedge aclk);
         f = (sel == 0) ? tb_event : (sel == 1) ? capture_event : aux_out;
         n--;
      end
      @(posedge aclk);
   endtask : hit
   task automatic pulse(input int b, input int sel, input logic e);
      want[b] <= 1'b1;
      hit(sel, 8);
      chk(f, e);
      want[b] <= 1'b0;
      repeat (4) @(posedge aclk);
   endtask : pulse
   task automatic t_regs;
      rdr(A_LO);
      chk(rd, 32'h0);
      rdr(A_HI);
      chk(rd, 32'h0);
      rdr(A_PER);
      chk(rd, 32'h0000FFFF);
      rdr(12'hFFC);
      chk(rs, sdg_pkg::RESP_SLVERR);
      wr(A_ST, 16'h0004);
      rdr(A_ST);
      chk(rd[2], 1'b0);
      $display("register test done");
   endtask : t_regs
   task automatic t_pins;
      wr(A_PER, 16'h0020);
      wr(A_HI, 16'h3F00);
      repeat (2) @(posedge aclk);
      chk(pin_oe, 6'h3F);
      chk(pin_out, 6'h2A);
      hit(0, 40);
      chk(f, 1'b1);
      wr(A_HI, 16'h8000);
      repeat (2) @(posedge aclk);
      chk(pin_oe, 6'h3F);
      hit(0, 40);
      repeat (2) @(posedge aclk);
      chk(pin_oe, 6'h00);
      $display("pin enable test done");
   endtask : t_pins
   task automatic t_shut;
      wr(A_HI, 16'h3F00);
      wr(A_SYN, 16'h0B1F);
      wr(A_LO, 16'h0040);
      want[25] <= 1'b1;
      repeat (8) @(posedge aclk);
      chk(pin_out, 6'h2A);
      want[25] <= 1'b0;
      want[24] <= 1'b1;
      repeat (8) @(posedge aclk);
      chk(pin_out, 6'h15);
      chk(pin_oe, 6'h3F);
      wr(A_SYN, 16'h001F);
      repeat (2) @(posedge aclk);
      chk(pin_oe, 6'h00);
      want[24] <= 1'b0;
      repeat (40) @(posedge aclk);
      rdr(A_ST);
      chk(rd[0], 1'b1);
      wr(A_ST, 16'h0001);
      repeat (3) @(posedge aclk);
      chk(pin_oe, 6'h3F);
      $display("shutdown test done");
   endtask : t_shut
   task automatic t_soft;
      wr(A_MSK, 16'h0001);
      hit(0, 40);
      wr(A_LO, 16'hD000);
      chk(pin_oe, 6'h3F);
      hit(0, 40);
      repeat (2) @(posedge aclk);
      rdr(A_ST);
      chk(rd[0], 1'b1);
      chk(irq, 1'b1);
      rdr(A_IST);
      chk(rd[0], 1'b1);
      repeat (2) @(posedge aclk);
      chk(irq, 1'b0);
      wr(A_LO, 16'hC000);
      repeat (40) @(posedge aclk);
      rdr(A_ST);
      chk(rd[0], 1'b0);
      $display("soft shutdown test done");
   endtask : t_soft
   task automatic t_cap;
      wr(A_LO, 16'h0000);
      for (int c = 0; c < 8; c++) begin
         wr(A_HI, {8'h00, 5'b11000, c[2:0]});
         pulse(c == 0 ? 23 : c < 4 ? 19 + c : c, 1, 1'b1);
      end
      wr(A_HI, 16'h0000);
      pulse(23, 1, 1'b0);
      wr(A_LO, 16'h1000);
      pulse(23, 1, 1'b1);
      wr(A_LO, 16'h0000);
      wr(A_HI, 16'h0040);
      wr(A_ST, 16'h0004);
      wr(A_LO, 16'h1000);
      pulse(23, 1, 1'b1);
      wr(A_HI, 16'h0080);
      wr(A_ST, 16'h0004);
      wr(A_LO, 16'h0000);
      repeat (4) @(posedge aclk);
      rdr(A_ST);
      chk(rd[1], 1'b1);
      $display("capture test done");
   endtask : t_cap
   task automatic t_sync;
      wr(A_PER, 16'hFFFF);
      wr(A_SYN, 16'h0010);
      wr(A_HI, 16'h0008);
      pulse(4, 0, 1'b1);
      wr(A_HI, 16'h0000);
      pulse(4, 2, 1'b0);
      wr(A_SYN, 16'h001E);
      pulse(4, 0, 1'b0);
      wr(A_HI, 16'h0010);
      aux_mode_sig <= 1'b1;
      repeat (3) @(posedge aclk);
      chk(aux_out, 1'b1);
      aux_mode_sig <= 1'b0;
      wr(A_PER, 16'h0100);
      wr(A_HI, 16'h0008);
      hit(2, 300);
      chk(f, 1'b1);
      $display("sync test done");
   endtask : t_sync
   task automatic results;
      $display("checked=%0d mismatches=%0d", checked, mismatches);
      if (mismatches == 0 && checked > 0) $display("Regression OK");
      else $display("Regression broken");
      $finish;
   endtask : results
   initial begin
      repeat (4) @(posedge aclk);
      aresetn <= 1'b1;
      repeat (2) @(posedge aclk);
      t_regs();
      t_pins();
      t_shut();
      t_soft();
      t_cap();
      t_sync();
      results();
   end
   initial begin
      #100000;
      mismatches++;
      results();
   end
endmodule : tb
